// [rtl/tgsa_pkg.sv]
/*
 package of tag group select / arbitration command logic: command codes, parameter
 and address field positions, memory layout constants, frame states.
 assumes a 128-bit page memory viewed as four 32-bit blocks per page.
*/
package tgsa_pkg;
	// command codes, the 2-bit command crc included
	localparam logic [7:0] TGSA_CMD_FAMILY   = 8'hF0; // family group command, arbitrary code here
	localparam logic [7:0] TGSA_CMD_PTR_AC   = 8'h4E;
	localparam logic [7:0] TGSA_CMD_PTR_GRP  = 8'h49;
	localparam logic [7:0] TGSA_CMD_PTR_LEEQ = 8'h5B;
	localparam logic [7:0] TGSA_CMD_PTR_GREQ = 8'h5C;
	localparam logic [7:0] TGSA_CMD_PTR_RND  = 8'h55;
	localparam logic [5:0] TGSA_REPEAT_PAT   = 6'b010010;
	localparam logic [7:0] TGSA_CMD_WAKE_S   = 8'h2A; // selected wake, arbitrary code
	localparam logic [7:0] TGSA_CMD_WAKE_U   = 8'h2B; // unselected wake, arbitrary code
	localparam logic [7:0] TGSA_CMD_RESET    = 8'h3C; // reset command, arbitrary code
	// parameter field positions
	localparam int TGSA_P_SEL   = 0;
	localparam int TGSA_P_MOD_L = 1;
	localparam int TGSA_P_BLK   = 3;
	localparam int TGSA_P_BYTE  = 4;
	localparam int TGSA_P_CRC   = 6;
	localparam int TGSA_P_SYM   = 7;
	// address byte positions
	localparam int TGSA_A_CARE  = 5;
	localparam int TGSA_A_BLK   = 6;
	// memory layout
	localparam logic [6:0] TGSA_FAMILY_MSB = 7'd125;
	localparam logic [6:0] TGSA_BLK3_LSB   = 7'd96;
	localparam logic [6:0] TGSA_BLK2_LSB   = 7'd64;
	localparam logic [6:0] TGSA_WAKE_START = 7'd103;
	localparam logic [3:0] TGSA_FAMILY_LEN = 4'd8;
	localparam logic [7:0] TGSA_WAKE_IDLEN = 8'd104;  // structure code plus 96 id bits
	localparam logic [4:0] TGSA_SLOTS      = 5'd16;
	typedef enum logic [2:0] {
		TGSA_IDLE  = 3'b000,
		TGSA_ARB   = 3'b001,
		TGSA_CRC   = 3'b010,
		TGSA_SLOT  = 3'b011,
		TGSA_WID   = 3'b100,
		TGSA_WCRC  = 3'b101
	} tgsa_state_t;
endpackage : tgsa_pkg

// [rtl/tgsa_comparator.sv]
/*
 serial comparator: msb-first compare of stored bits against forward bits.
 assumes bits arrive one per strobe and clr_i opens a new comparison.
*/
`timescale 1ns/1ps
module tgsa_comparator
	import tgsa_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic clr_i,
	input  wire logic bit_vld_i,
	input  wire logic mem_bit_i,
	input  wire logic fwd_bit_i,
	input  wire logic dont_care_i,
	output logic      eq_o,
	output logic      mem_lt_o,
	output logic      mem_gt_o
);
	logic decided_q;
	logic lt_q;
	logic gt_q;
	logic neq_q;

	// first differing bit decides the order; a don't-care bit is skipped
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clr_i)
		begin
			decided_q <= 1'b0;
			lt_q      <= 1'b0;
			gt_q      <= 1'b0;
			neq_q     <= 1'b0;
		end
		else if (bit_vld_i && !dont_care_i && (mem_bit_i != fwd_bit_i))
		begin
			neq_q <= 1'b1;
			if (!decided_q)
			begin
				decided_q <= 1'b1;
				lt_q      <= fwd_bit_i;
				gt_q      <= mem_bit_i;
			end
		end
	end

	assign eq_o     = !neq_q;
	assign mem_lt_o = lt_q;
	assign mem_gt_o = gt_q;
endmodule : tgsa_comparator

// [rtl/tgsa_core.sv]
/*
 tag command logic for group selection, pointer anticollision, repeat and wake.
 assumes an outer decoder presenting command/parameter/address bytes, forward
 bits with strobes, end symbols, and a crc result; memory read is combinational.
*/
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// RQ1 - parameter bit 0 zero addresses all tags, one only candidate-marked tags; the code also takes won tags and drops done ones
// RQ2 - frame: header, command, parameter, eot, header, arbitration, end, crc, eot
// RQ3 - family group arbitration begins at page 0 bit 125
// RQ4 - first forward bit differing from memory sets arbitration lost
// RQ5 - all-zero first family byte overrides arbitration loss, backscatter stays on; code drops backscatter from first mismatch until the eighth bit
// RQ6 - reset command clears candidate mark; otherwise kept
// RQ7 - parameter bit 3 picks block 3 (0) or block 2 (1)
// RQ8 - parameter bits 5:4 pick start byte within block
// RQ9 - care bit set and forward one makes comparison don't-care
// RQ10 - pointer anticollision is 4Eh, pointer group 49h
// RQ11 - pointer group updates candidate mark; anticollision updates won and done
// RQ12 - pointer parameter: bit 7 addressing, bit 6 crc source, 5:3 short address
// RQ13 - parameter bits 2:1 select return modulation
// RQ14 - address byte: block in 7:6, care bit 5, bit position 4:0
// RQ15 - 5B sets mark if stored at most forward; 5C if at least
// RQ16 - 55h random pointer anticollision, 8-bit random prefix
// RQ17 - repeat re-runs last long command without overwriting stored command
// RQ18 - repeat without stored command signals unknown-command error
// RQ19 - repeat byte is 010010 plus two crc bits
// RQ20 - selected wake: (won or mark) and not done; unselected: all zero
// RQ21 - wake answer opens with 16 one-bit slots, only random slot modulated
// RQ22 - then structure code, lower 96 id bits, crc, eot
// RQ23 - while arbitration lost, no backscatter
module tgsa_core
	import tgsa_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         cmd_vld_i,
	input  wire logic [7:0]   cmd_i,
	input  wire logic [7:0]   param_i,
	input  wire logic [7:0]   addr_i,
	input  wire logic         hdr_i,
	input  wire logic         fwd_vld_i,
	input  wire logic         fwd_bit_i,
	input  wire logic         eof_i,
	input  wire logic         crc_ok_i,
	input  wire logic         crc_vld_i,
	input  wire logic [3:0]   rnd_i,
	input  wire logic [1:0]   mem_page_i,
	input  wire logic [127:0] mem_data_i,
	input  wire logic         rtn_tick_i,
	output logic [1:0]        mem_page_o,
	output logic [1:0]        ret_mod_o,
	output logic              crc_src_o,
	output logic              sym_addr_o,
	output logic [2:0]        short_addr_o,
	output logic              bs_en_o,
	output logic              bs_bit_o,
	output logic              rnd_phase_o,
	output logic              err_unknown_o,
	output logic              cand_mark_o,
	output logic              won_flag_o,
	output logic              done_flag_o,
	output logic              arb_lost_o
);
	tgsa_state_t state_q;
	logic [7:0]  cmd_q;
	logic [7:0]  param_q;
	logic [7:0]  addr_q;
	logic        cmd_known_q;
	logic [6:0]  ptr_q;
	logic [7:0]  cnt_q;
	logic        lost_q;
	logic        joker_q;
	logic        cand_q;
	logic        won_q;
	logic        done_q;
	logic        err_q;
	logic        bs_bit_q;
	logic        addressed_q;
	logic        wake_q;
	logic [4:0]  slot_q;
	logic        is_long;
	logic        is_repeat;
	logic        is_wake_s;
	logic        is_wake_u;
	logic [7:0]  cur_cmd;
	logic [7:0]  cur_param;
	logic [7:0]  cur_addr;
	logic        sel_ok;
	logic        mem_bit;
	logic        dont_care;
	logic        cmp_eq;
	logic        cmp_lt;
	logic        cmp_gt;
	logic        pass;
	logic        is_ptr;
	logic [6:0]  start_ptr;
	logic        rnd_pre;

	////////////////////////////////////////////////////////////////////////
	// command classification
	assign is_ptr    = (cmd_q == TGSA_CMD_PTR_AC) || (cmd_q == TGSA_CMD_PTR_GRP) // RQ10
		|| (cmd_q == TGSA_CMD_PTR_LEEQ) || (cmd_q == TGSA_CMD_PTR_GREQ)
		|| (cmd_q == TGSA_CMD_PTR_RND);
	assign is_long   = (cmd_i == TGSA_CMD_FAMILY) || (cmd_i == TGSA_CMD_PTR_AC)
		|| (cmd_i == TGSA_CMD_PTR_GRP) || (cmd_i == TGSA_CMD_PTR_LEEQ)
		|| (cmd_i == TGSA_CMD_PTR_GREQ) || (cmd_i == TGSA_CMD_PTR_RND);
	// the group pointer code shares the repeat pattern, so a long command code wins
	assign is_repeat = (cmd_i[7:2] == TGSA_REPEAT_PAT) && !is_long; // RQ19
	assign is_wake_s = (cmd_i == TGSA_CMD_WAKE_S);
	assign is_wake_u = (cmd_i == TGSA_CMD_WAKE_U);
	// a repeat reuses the stored frame fields, never its own byte
	assign cur_cmd   = is_repeat ? cmd_q : cmd_i; // RQ17
	assign cur_param = is_repeat ? param_q : param_i;
	assign cur_addr  = is_repeat ? addr_q : addr_i;
	// selection control: everyone, or candidate/won and not done
	assign sel_ok    = !cur_param[TGSA_P_SEL] || ((cand_q || won_q) && !done_q); // RQ1

	// start bit: family byte, id-page block/byte, or pointer address
	always_comb
	begin
		if (cur_cmd != TGSA_CMD_FAMILY)
			start_ptr = {cur_addr[TGSA_A_BLK +: 2], cur_addr[4:0]}; // RQ14
		else if (cur_param[5:3] == 3'b010)
			start_ptr = TGSA_FAMILY_MSB; // RQ3
		else
			start_ptr = (cur_param[TGSA_P_BLK] ? TGSA_BLK2_LSB : TGSA_BLK3_LSB) // RQ7
				+ {2'b00, cur_param[5:4], 3'b111}; // RQ8
	end

	////////////////////////////////////////////////////////////////////////
	// memory bit and comparison
	assign mem_page_o = mem_page_i;
	assign rnd_pre    = (cmd_q == TGSA_CMD_PTR_RND) && (cnt_q < 8'd8); // RQ16
	assign mem_bit    = rnd_pre ? rnd_i[cnt_q[1:0]] : mem_data_i[ptr_q];
	// care bit with forward one masks this position
	assign dont_care  = is_ptr && addr_q[TGSA_A_CARE] && fwd_bit_i; // RQ9

	tgsa_comparator u_cmp (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.clr_i       (cmd_vld_i),
		.bit_vld_i   (state_q == TGSA_ARB && fwd_vld_i),
		.mem_bit_i   (mem_bit),
		.fwd_bit_i   (fwd_bit_i),
		.dont_care_i (dont_care),
		.eq_o        (cmp_eq),
		.mem_lt_o    (cmp_lt),
		.mem_gt_o    (cmp_gt)
	);

	// ordered compare for the leeq/greq group variants
	always_comb
	begin
		case (cmd_q)
			TGSA_CMD_PTR_LEEQ: pass = !cmp_gt; // RQ15
			TGSA_CMD_PTR_GREQ: pass = !cmp_lt; // RQ15
			default:           pass = !lost_q;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// stored command register: long commands only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_q       <= 8'h00;
			param_q     <= 8'h00;
			addr_q      <= 8'h00;
			cmd_known_q <= 1'b0;
		end
		else if (cmd_vld_i && is_long && !is_repeat)
		begin
			cmd_q       <= cmd_i; // RQ17
			param_q     <= param_i;
			addr_q      <= addr_i;
			cmd_known_q <= 1'b1;
		end
	end

	// unknown command error on repeat with nothing stored, held until the first end symbol
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			err_q <= 1'b0;
		else if (cmd_vld_i)
			err_q <= is_repeat && !cmd_known_q; // RQ18
		else if (eof_i)
			err_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q     <= TGSA_IDLE;
			ptr_q       <= 7'd0;
			cnt_q       <= 8'd0;
			addressed_q <= 1'b0;
			wake_q      <= 1'b0;
			slot_q      <= 5'd0;
		end
		else
		begin
			case (state_q)
				TGSA_IDLE:
				begin
					if (cmd_vld_i && (is_long || (is_repeat && cmd_known_q)))
					begin
						addressed_q <= sel_ok;
						ptr_q       <= start_ptr;
						cnt_q       <= 8'd0;
						wake_q      <= 1'b0;
						state_q     <= TGSA_ARB; // RQ2
					end
					else if (cmd_vld_i && (is_wake_s || is_wake_u))
					begin
						addressed_q <= is_wake_s ? ((won_q || cand_q) && !done_q) // RQ20
							: (!won_q && !cand_q && !done_q);
						wake_q      <= 1'b1;
						slot_q      <= 5'd0;
						state_q     <= TGSA_SLOT;
					end
				end
				TGSA_ARB:
				begin
					if (eof_i)
						state_q <= TGSA_CRC;
					else if (fwd_vld_i)
					begin
						cnt_q <= cnt_q + 8'd1;
						if (!rnd_pre)
							ptr_q <= ptr_q - 7'd1; // auto decrement
					end
				end
				TGSA_CRC:
				begin
					if (crc_vld_i)
						state_q <= TGSA_IDLE;
				end
				TGSA_SLOT:
				begin
					if (rtn_tick_i)
					begin
						slot_q <= slot_q + 5'd1;
						if (slot_q == TGSA_SLOTS - 5'd1)
						begin
							ptr_q   <= TGSA_WAKE_START;
							cnt_q   <= 8'd0;
							state_q <= TGSA_WID;
						end
					end
				end
				TGSA_WID:
				begin
					if (rtn_tick_i)
					begin
						ptr_q <= ptr_q - 7'd1;
						cnt_q <= cnt_q + 8'd1;
						if (cnt_q == TGSA_WAKE_IDLEN - 8'd1)
							state_q <= TGSA_WCRC; // RQ22
					end
				end
				TGSA_WCRC:
				begin
					if (eof_i)
						state_q <= TGSA_IDLE;
				end
				default: state_q <= TGSA_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arbitration lost and family joker
	always_ff @(posedge clk_i)
	begin
		if (rst_i || hdr_i || (cmd_vld_i && cmd_i == TGSA_CMD_RESET))
		begin
			lost_q  <= 1'b0;
			joker_q <= 1'b1;
		end
		else if (state_q == TGSA_ARB && fwd_vld_i)
		begin
			if (cmd_q == TGSA_CMD_FAMILY && cnt_q < {4'd0, TGSA_FAMILY_LEN})
				joker_q <= joker_q && !fwd_bit_i;
			if (!dont_care && mem_bit != fwd_bit_i && cmd_q != TGSA_CMD_PTR_LEEQ
				&& cmd_q != TGSA_CMD_PTR_GREQ)
				lost_q <= 1'b1; // RQ4
			if (cmd_q == TGSA_CMD_FAMILY && cnt_q == {4'd0, TGSA_FAMILY_LEN} - 8'd1
				&& joker_q && !fwd_bit_i)
				lost_q <= 1'b0; // RQ5
		end
		else if (state_q == TGSA_CRC && crc_vld_i && !crc_ok_i)
			lost_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// selection flags: updated at crc acceptance, where a failed family or group compare also clears the mark; reset clears all three
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cand_q <= 1'b0;
			won_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else if (cmd_vld_i && cmd_i == TGSA_CMD_RESET)
		begin
			cand_q <= 1'b0; // RQ6
			won_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else if (state_q == TGSA_CRC && crc_vld_i && crc_ok_i && addressed_q)
		begin
			if (cmd_q == TGSA_CMD_PTR_AC || cmd_q == TGSA_CMD_PTR_RND)
			begin
				if (won_q)
					done_q <= 1'b1; // RQ11
				won_q <= pass; // RQ11
			end
			else
				cand_q <= pass; // RQ11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// return link: one bit per slot, then stored bits; silent while lost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bs_bit_q <= 1'b0;
		else if (state_q == TGSA_SLOT)
			bs_bit_q <= (slot_q[3:0] == rnd_i); // RQ21
		else
			bs_bit_q <= mem_data_i[ptr_q];
	end

	assign bs_bit_o      = bs_bit_q;
	assign bs_en_o       = addressed_q && !lost_q && state_q != TGSA_IDLE; // RQ23
	assign rnd_phase_o   = rnd_pre;
	assign err_unknown_o = err_q;
	assign ret_mod_o     = param_q[TGSA_P_MOD_L +: 2]; // RQ13
	assign crc_src_o     = param_q[TGSA_P_CRC]; // RQ12
	assign sym_addr_o    = param_q[TGSA_P_SYM]; // RQ12
	assign short_addr_o  = param_q[5:3]; // RQ12
	assign cand_mark_o   = cand_q;
	assign won_flag_o    = won_q;
	assign done_flag_o   = done_q;
	assign arb_lost_o    = lost_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_lost_silent;
		@(posedge clk_i) disable iff (rst_i) lost_q |-> !bs_en_o;
	endproperty
	a_lost_silent: assert property (p_lost_silent) else $error("backscatter while lost"); // RQ23

	property p_repeat_keeps;
		@(posedge clk_i) disable iff (rst_i) (cmd_vld_i && is_repeat) |=> (cmd_q == $past(cmd_q));
	endproperty
	a_repeat_keeps: assert property (p_repeat_keeps) else $error("repeat overwrote command"); // RQ17

	property p_err_rep;
		@(posedge clk_i) disable iff (rst_i) (cmd_vld_i && is_repeat && !cmd_known_q) |=> err_q;
	endproperty
	a_err_rep: assert property (p_err_rep) else $error("no unknown command error"); // RQ18

	property p_reset_mark;
		@(posedge clk_i) disable iff (rst_i) (cmd_vld_i && cmd_i == TGSA_CMD_RESET) |=> !cand_q;
	endproperty
	a_reset_mark: assert property (p_reset_mark) else $error("mark survived reset"); // RQ6

	property p_mismatch_lost;
		@(posedge clk_i) disable iff (rst_i)
			(state_q == TGSA_ARB && fwd_vld_i && !hdr_i && !dont_care && mem_bit != fwd_bit_i
			&& cmd_q != TGSA_CMD_FAMILY && cmd_q != TGSA_CMD_PTR_LEEQ && cmd_q != TGSA_CMD_PTR_GREQ)
			|=> lost_q;
	endproperty
	a_mismatch_lost: assert property (p_mismatch_lost) else $error("mismatch not lost"); // RQ4

	property p_mod_sel;
		@(posedge clk_i) disable iff (rst_i)
			(cmd_vld_i && is_long) |=> (ret_mod_o == $past(param_i[TGSA_P_MOD_L +: 2]));
	endproperty
	a_mod_sel: assert property (p_mod_sel) else $error("return modulation wrong"); // RQ13

	sequence s_slots_done;
		(state_q == TGSA_SLOT && rtn_tick_i && slot_q == 5'd15);
	endsequence
	property p_slot_to_id;
		@(posedge clk_i) disable iff (rst_i) s_slots_done |=> (state_q == TGSA_WID && ptr_q == 7'd103);
	endproperty
	a_slot_to_id: assert property (p_slot_to_id) else $error("slot region length wrong"); // RQ21

	property p_wake_u;
		@(posedge clk_i) disable iff (rst_i)
			(state_q == TGSA_IDLE && cmd_vld_i && is_wake_u && (won_q || cand_q || done_q)) |=> !addressed_q;
	endproperty
	a_wake_u: assert property (p_wake_u) else $error("unselected wake misaddressed"); // RQ20
endmodule : tgsa_core

// [bench/tgsa_reader_model.sv]
/*
 reader model: the far party sending command, header, forward bits, end symbol and crc result.
 assumes the bench calls its tasks; every strobe changes on a falling clock edge.
*/
`timescale 1ns/1ps
module tgsa_reader_model
(
	input  wire logic  clk_i,
	output logic       cmd_vld_o,
	output logic [7:0] cmd_o,
	output logic [7:0] param_o,
	output logic [7:0] addr_o,
	output logic       hdr_o,
	output logic       fwd_vld_o,
	output logic       fwd_bit_o,
	output logic       eof_o,
	output logic       crc_vld_o,
	output logic       crc_ok_o,
	output logic       tick_o
);
	//////////////////////////////////////////////////////////////////////////////
	// all strobes low from time zero so nothing is taken during reset
	initial
	begin
		{cmd_vld_o, hdr_o, fwd_vld_o, fwd_bit_o, eof_o, crc_vld_o, crc_ok_o, tick_o} = 8'h00;
		{cmd_o, param_o, addr_o} = 24'h00_0000;
	end

	// command byte with its fields; fields stay put after the strobe
	task automatic send_cmd(input logic [7:0] c, input logic [7:0] p, input logic [7:0] a);
		@(negedge clk_i);
		cmd_o     = c;
		param_o   = p;
		addr_o    = a;
		cmd_vld_o = 1'b1;
		@(negedge clk_i);
		cmd_vld_o = 1'b0;
	endtask : send_cmd

	// return header strobe
	task automatic header();
		@(negedge clk_i);
		hdr_o = 1'b1;
		@(negedge clk_i);
		hdr_o = 1'b0;
	endtask : header

	// forward bits msb first, from index hi down to lo
	task automatic send_bits(input logic [7:0] b, input int hi, input int lo);
		for (int i = hi; i >= lo; i--)
		begin
			@(negedge clk_i);
			fwd_bit_o = b[i];
			fwd_vld_o = 1'b1;
			@(negedge clk_i);
			fwd_vld_o = 1'b0;
			fwd_bit_o = ~b[i]; // released line shows the inverse, so a stale bit never matches
		end
	endtask : send_bits

	// end symbol strobe
	task automatic end_sym();
		@(negedge clk_i);
		eof_o = 1'b1;
		@(negedge clk_i);
		eof_o = 1'b0;
	endtask : end_sym

	// return link bit ticks
	task automatic tick(input int n);
		repeat (n)
		begin
			@(negedge clk_i);
			tick_o = 1'b1;
			@(negedge clk_i);
			tick_o = 1'b0;
		end
	endtask : tick

	// end symbol then crc verdict closing the arbitration
	task automatic finish(input logic ok);
		end_sym();
		@(negedge clk_i);
		crc_ok_o  = ok;
		crc_vld_o = 1'b1;
		@(negedge clk_i);
		crc_vld_o = 1'b0;
	endtask : finish

	// whole long frame; the end-of-transfer pairs are absorbed by the outer decoder
	task automatic frame(input logic [7:0] c, input logic [7:0] p, input logic [7:0] a, input logic [7:0] b,
		input logic ok);
		send_cmd(c, p, a);
		header();
		send_bits(b, 7, 0);
		finish(ok);
	endtask : frame
endmodule : tgsa_reader_model

// [bench/tag_group_select_arbitration_test.sv]
/*
 testbench of the tag command logic: a reader model sends frames, each task judges the flags.
 assumes a fixed memory page and a fixed random slot; the crc verdict is driven directly.
*/
`timescale 1ns/1ps
module tag_group_select_arbitration_test
	import tgsa_pkg::*;
();
	logic [127:0] mem_image = 128'hA5C3_0F96_5A3C_E1F0_1234_8765_4321_FEDC;
	logic [3:0]   rnd = 4'h5;
	logic [1:0]   page = 2'b10;
	logic [1:0]   page_seen;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       cmd_vld, hdr, fwd_vld, fwd_bit, eof, crc_vld, crc_ok, tick;
	logic [7:0] cmd, param, addr;
	logic [1:0] ret_mod;
	logic [2:0] short_addr;
	logic       crc_src, sym_addr, bs_en, bs_bit, rnd_phase, err_unknown, cand_mark, won_flag, done_flag, arb_lost;
	int         err_count = 0;
	int         checks_done = 0;

	//////////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	always #12.5 clk = ~clk;

	tgsa_reader_model u_tgsa_reader_model (.clk_i(clk), .cmd_vld_o(cmd_vld), .cmd_o(cmd), .param_o(param),
		.addr_o(addr), .hdr_o(hdr), .fwd_vld_o(fwd_vld), .fwd_bit_o(fwd_bit), .eof_o(eof), .crc_vld_o(crc_vld),
		.crc_ok_o(crc_ok), .tick_o(tick));

	// random slot and page are driven from bench variables so slot and id bits are predictable
	tgsa_core u_tgsa_core (.clk_i(clk), .rst_i(rst), .cmd_vld_i(cmd_vld), .cmd_i(cmd), .param_i(param),
		.addr_i(addr), .hdr_i(hdr), .fwd_vld_i(fwd_vld), .fwd_bit_i(fwd_bit), .eof_i(eof), .crc_ok_i(crc_ok),
		.crc_vld_i(crc_vld), .rnd_i(rnd), .mem_page_i(page), .mem_data_i(mem_image), .rtn_tick_i(tick),
		.mem_page_o(page_seen), .ret_mod_o(ret_mod), .crc_src_o(crc_src), .sym_addr_o(sym_addr),
		.short_addr_o(short_addr), .bs_en_o(bs_en), .bs_bit_o(bs_bit), .rnd_phase_o(rnd_phase),
		.err_unknown_o(err_unknown), .cand_mark_o(cand_mark), .won_flag_o(won_flag),
		.done_flag_o(done_flag), .arb_lost_o(arb_lost));

	//////////////////////////////////////////////////////////////////////////////
	// verdict and comparison helpers
	task automatic final_report();
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// flags land one edge after the crc verdict, so two cycles of slack
	task automatic run(input logic [7:0] c, input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
		u_tgsa_reader_model.frame(c, p, a, b, 1'b1);
		idle(2);
	endtask : run

	task automatic clear_flags();
		u_tgsa_reader_model.send_cmd(TGSA_CMD_RESET, 8'h00, 8'h00);
		idle(2);
		check({won_flag, done_flag, cand_mark}, 8'h00);
	endtask : clear_flags

	// opens a wake answer, judges whether backscatter is allowed, then lets it run out
	task automatic wake_gate(input logic [7:0] c, input logic exp);
		u_tgsa_reader_model.send_cmd(c, 8'h00, 8'h00);
		u_tgsa_reader_model.tick(1);
		check(bs_en, exp);
		u_tgsa_reader_model.tick(127);
		u_tgsa_reader_model.end_sym();
		idle(2);
	endtask : wake_gate

	//////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_repeat_empty();
		check({bs_en, cand_mark, won_flag, done_flag, arb_lost}, 8'h00);
		check(page_seen, 2'b10);
		u_tgsa_reader_model.send_cmd({TGSA_REPEAT_PAT, 2'b00}, 8'h00, 8'h00);
		idle(2);
		check(err_unknown, 1'b1);
		u_tgsa_reader_model.end_sym();
		idle(2);
		check(err_unknown, 1'b0);
	endtask : t_repeat_empty

	task automatic t_family();
		run(TGSA_CMD_FAMILY, 8'h12, 8'h00, mem_image[125 -: 8]);
		check({cand_mark, arb_lost}, 8'h02);
		check(ret_mod, 2'b01);
		clear_flags();
		u_tgsa_reader_model.send_cmd(TGSA_CMD_FAMILY, 8'h14, 8'h00);
		u_tgsa_reader_model.header();
		u_tgsa_reader_model.send_bits(mem_image[125 -: 8] ^ 8'h80, 7, 7);
		idle(1);
		check({bs_en, arb_lost}, 8'h01);
		u_tgsa_reader_model.send_bits(mem_image[125 -: 8], 6, 0);
		u_tgsa_reader_model.finish(1'b1);
		idle(2);
		check(cand_mark, 1'b0);
		check(ret_mod, 2'b10);
	endtask : t_family

	// all-zero family byte: lost after the first bit, forgiven after the eighth
	task automatic t_joker();
		u_tgsa_reader_model.send_cmd(TGSA_CMD_FAMILY, 8'h10, 8'h00);
		u_tgsa_reader_model.header();
		u_tgsa_reader_model.send_bits(8'h00, 7, 7);
		idle(1);
		check(arb_lost, 1'b1);
		u_tgsa_reader_model.send_bits(8'h00, 6, 0);
		idle(1);
		check({bs_en, arb_lost}, 8'h02);
		u_tgsa_reader_model.finish(1'b1);
		idle(2);
		check(cand_mark, 1'b1);
	endtask : t_joker

	task automatic t_block();
		clear_flags();
		run(TGSA_CMD_FAMILY, 8'h38, 8'h00, mem_image[95 -: 8]);
		check(cand_mark, 1'b1);
		clear_flags();
		run(TGSA_CMD_FAMILY, 8'h00, 8'h00, mem_image[103 -: 8]);
		check(cand_mark, 1'b1);
	endtask : t_block

	// pointer group, anticollision and repeat share one start bit (block 1, bit 31); wake reads from bit 103
	task automatic t_pointer();
		logic [7:0] code;
		int         ones;
		ones = 0;
		code = 8'h00;
		clear_flags();
		run(TGSA_CMD_PTR_GRP, 8'h01, 8'h5F, mem_image[63 -: 8]);
		check(cand_mark, 1'b0);
		run(TGSA_CMD_PTR_GRP, 8'hEE, 8'h5F, mem_image[63 -: 8]);
		check(cand_mark, 1'b1);
		check({sym_addr, crc_src, short_addr, ret_mod}, 8'h77);
		run(TGSA_CMD_PTR_AC, 8'h00, 8'h5F, mem_image[63 -: 8]);
		check({won_flag, done_flag, ret_mod}, 8'h08);
		u_tgsa_reader_model.send_cmd(TGSA_CMD_WAKE_S, 8'h00, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			u_tgsa_reader_model.tick(1);
			ones += int'(bs_bit);
		end
		check(bs_en, 1'b1);
		check(ones[7:0], 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			u_tgsa_reader_model.tick(1);
			code = {code[6:0], bs_bit};
		end
		check(code, mem_image[103 -: 8]);
		u_tgsa_reader_model.tick(112);
		u_tgsa_reader_model.end_sym();
		idle(2);
		run({TGSA_REPEAT_PAT, 2'b00}, 8'h00, 8'h00, mem_image[63 -: 8]);
		check({err_unknown, won_flag, done_flag}, 8'h03);
		wake_gate(TGSA_CMD_WAKE_S, 1'b0);
		wake_gate(TGSA_CMD_WAKE_U, 1'b0);
		clear_flags();
		wake_gate(TGSA_CMD_WAKE_U, 1'b1);
	endtask : t_pointer

	// stored byte 12h against forward 13h and 11h; then ones only with and without care bit
	task automatic t_compare();
		run(TGSA_CMD_PTR_LEEQ, 8'h00, 8'h5F, 8'h13);
		check({cand_mark, arb_lost}, 8'h02);
		clear_flags();
		run(TGSA_CMD_PTR_GREQ, 8'h00, 8'h5F, 8'h13);
		check(cand_mark, 1'b0);
		run(TGSA_CMD_PTR_GREQ, 8'h00, 8'h5F, 8'h11);
		check(cand_mark, 1'b1);
		clear_flags();
		run(TGSA_CMD_PTR_GRP, 8'h00, 8'h5F, 8'hFF);
		check({cand_mark, arb_lost}, 8'h01);
		run(TGSA_CMD_PTR_GRP, 8'h00, 8'h7F, 8'hFF);
		check(cand_mark, 1'b1);
		u_tgsa_reader_model.send_cmd(TGSA_CMD_PTR_RND, 8'h00, 8'h5F);
		u_tgsa_reader_model.header();
		idle(1);
		check(rnd_phase, 1'b1);
		u_tgsa_reader_model.send_bits(8'hFF, 7, 0);
		u_tgsa_reader_model.finish(1'b0);
		idle(2);
	endtask : t_compare

	//////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_repeat_empty();
		t_family();
		t_joker();
		t_block();
		t_pointer();
		t_compare();
		final_report();
	end

	// the whole run needs about 1500 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
endmodule : tag_group_select_arbitration_test
